// *** src/ugls_top.v ***
// Uplink gain loop supervisor top with Avalon-MM register slave
// Summary of operation
// RQ1: Attenuation setting comes from retained storage and is restored after power loss.
// RQ2: Absent or low input forces attenuator maximum; user setting untouched.
// RQ3: After input returns, drive ramps down slowly until gain error reaches zero.
// RQ4: While amplifier saturated, attenuation setting increments by one dB per iteration.
// RQ5: Saturation-raised setting is reported and stays fixed afterwards.
// RQ6: Loop fault and summary fault when error nonzero over five of 255 iterations.
// RQ7: Gain loop enabled with RF commanded off registers the loop fault.
// RQ8: Normal to low input transition flags insufficient input, summary, max attenuation.
// RQ9: Normal to high input transition flags excessive input; saturation stepping continues.
// RQ10: Fault query returns loop, insufficient and excessive flags.
// RQ11: Manual mode disables loop and monitoring; summary fault reads OK.
// RQ12: Manual mode accepts 0 to 55 dB integer settings without decimal point.
// RQ13: Gain loop mode limits setting to 0 through 20 dB with decimal point.
// RQ14: Each iteration computes gain error and steers attenuator drive toward zero.
// RQ15: Loop fault clears once window count no longer exceeds the limit.
//
// The implementer's own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "ugls_map.vh"
module ugls_top (
    // Clock and reset
    input wire i_sys_clk,
    input wire i_resetn,
    // Avalon-MM slave
    input wire [3:0] i_avs_address,
    input wire i_avs_read,
    input wire i_avs_write,
    input wire [31:0] i_avs_writedata,
    output reg [31:0] o_avs_readdata,
    output reg o_avs_waitrequest,
    // Retained setting store
    input wire [5:0] i_saved_setting,
    output reg [5:0] o_saved_setting,
    output reg o_save_strobe,
    // Detectors and loop timing
    input wire i_iter_strobe,
    input wire signed [7:0] i_in_power_dbm,
    input wire i_in_present,
    input wire signed [7:0] i_gain_error_db,
    input wire i_pa_saturated,
    // Attenuator and faults
    output reg [5:0] o_atten_drive,
    output reg o_summary_fault,
    output reg o_irq
);
    // ****************************************
    // Helpers
    // ****************************************
    function [5:0] clamp_att;
        input [5:0] val;
        input [5:0] lim;
        begin
            clamp_att = (val > lim) ? lim : val;
        end
    endfunction

    // ****************************************
    // State
    // ****************************************
    reg enable_reg;
    reg rf_on_reg;
    reg loaded_reg;
    reg [5:0] setting_reg;
    reg [5:0] drive_reg;
    reg low_reg;
    reg high_reg;
    reg loop_reg;
    reg in_low_prev_reg;
    reg in_high_prev_reg;
    reg [`UGLS_EVT_W-1:0] status_reg;
    reg [`UGLS_EVT_W-1:0] mask_reg;
    reg [7:0] win_ptr_reg;
    reg [7:0] win_count_reg;
    reg win_full_reg;
    reg old_ok_reg;
    reg [3:0] ramp_reg;
    reg iter_d_reg;
    reg cur_nz_reg;
    wire old_nz;
    wire in_low = !i_in_present || (i_in_power_dbm <= $signed(`UGLS_LOW_DBM));
    wire in_high = i_in_present && (i_in_power_dbm > $signed(`UGLS_HIGH_DBM));
    wire [5:0] lim = enable_reg ? `UGLS_ATT_AUTO_MAX : `UGLS_ATT_MAN_MAX;
    // Writes land only at the accept edge, with waitrequest low
    wire wr_hit = i_avs_write && !o_avs_waitrequest;
    wire rd_hit = i_avs_read && o_avs_waitrequest;
    wire req_seen = (i_avs_read || i_avs_write) && o_avs_waitrequest;
    wire nz_now = (i_gain_error_db != `UGLS_ZERO8) || !rf_on_reg; // RQ7
    wire [7:0] count_next = win_count_reg + {7'h00, cur_nz_reg}
        - {7'h00, old_nz & old_ok_reg};
    wire loop_now = count_next > `UGLS_WIN_LIMIT; // RQ6 RQ15
    wire low_evt = enable_reg && i_iter_strobe && in_low && !in_low_prev_reg; // RQ8
    wire high_evt = enable_reg && i_iter_strobe && in_high && !in_high_prev_reg; // RQ9
    wire sat_evt = enable_reg && i_iter_strobe && i_pa_saturated;
    wire loop_evt = enable_reg && iter_d_reg && loop_now && !loop_reg;
    wire [`UGLS_EVT_W-1:0] evt_set = {sat_evt, high_evt, low_evt, loop_evt};
    wire [`UGLS_EVT_W-1:0] w1c = (wr_hit && i_avs_address == `UGLS_REG_STATUS) ?
        i_avs_writedata[`UGLS_EVT_W-1:0] : `UGLS_EVT_ZERO;
    wire [`UGLS_EVT_W-1:0] status_next = (status_reg & ~w1c) | evt_set;

    // ****************************************
    // Nonzero history window
    // ****************************************
    ugls_hist_mem u_hist (
        .i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn),
        .i_wr_en(i_iter_strobe && enable_reg),
        .i_wr_addr(win_ptr_reg),
        .i_wr_data(nz_now),
        .i_rd_addr(win_ptr_reg),
        .o_rd_data(old_nz)
    );

    // ****************************************
    // Register bus
    // ****************************************
    always @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata <= 32'h00000000;
        end else begin
            // One wait cycle then accept; keeps decode registered
            o_avs_waitrequest <= !req_seen;
            if (rd_hit) begin
                case (i_avs_address)
                    `UGLS_REG_CTRL: o_avs_readdata <= {30'h00000000, rf_on_reg, enable_reg};
                    `UGLS_REG_SETTING: o_avs_readdata <= {26'h0000000, setting_reg}; // RQ5
                    `UGLS_REG_STATUS: o_avs_readdata <= {28'h0000000, status_reg};
                    `UGLS_REG_MASK: o_avs_readdata <= {28'h0000000, mask_reg};
                    `UGLS_REG_FAULTS: o_avs_readdata <= {26'h0000000, enable_reg,
                        o_summary_fault, i_pa_saturated & enable_reg,
                        high_reg, low_reg, loop_reg}; // RQ10 RQ13 RQ12
                    `UGLS_REG_ATTEN: o_avs_readdata <= {26'h0000000, drive_reg};
                    default: o_avs_readdata <= 32'h00000000;
                endcase
            end
        end
    end

    // ****************************************
    // Control loop
    // ****************************************
    always @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            enable_reg <= 1'b1;
            rf_on_reg <= 1'b1;
            loaded_reg <= 1'b0;
            setting_reg <= `UGLS_ATT_ZERO;
            drive_reg <= `UGLS_ATT_MAN_MAX;
            low_reg <= 1'b0;
            high_reg <= 1'b0;
            loop_reg <= 1'b0;
            in_low_prev_reg <= 1'b0;
            in_high_prev_reg <= 1'b0;
            status_reg <= `UGLS_EVT_ZERO;
            mask_reg <= `UGLS_EVT_ZERO;
            win_ptr_reg <= `UGLS_ZERO8;
            win_count_reg <= `UGLS_ZERO8;
            win_full_reg <= 1'b0;
            old_ok_reg <= 1'b0;
            ramp_reg <= `UGLS_ZERO4;
            iter_d_reg <= 1'b0;
            cur_nz_reg <= 1'b0;
            o_saved_setting <= `UGLS_ATT_ZERO;
            o_save_strobe <= 1'b0;
            o_atten_drive <= `UGLS_ATT_MAN_MAX;
            o_summary_fault <= 1'b0;
            o_irq <= 1'b0;
        end else begin
            o_save_strobe <= 1'b0;
            status_reg <= status_next;
            iter_d_reg <= i_iter_strobe && enable_reg;
            if (!loaded_reg) begin
                loaded_reg <= 1'b1;
                setting_reg <= clamp_att(i_saved_setting, lim); // RQ1
            end else if (wr_hit && i_avs_address == `UGLS_REG_SETTING) begin
                setting_reg <= clamp_att(i_avs_writedata[5:0], lim); // RQ12 RQ13
                o_saved_setting <= clamp_att(i_avs_writedata[5:0], lim); // RQ1
                o_save_strobe <= 1'b1;
            end else if (sat_evt && setting_reg < `UGLS_ATT_AUTO_MAX) begin
                setting_reg <= setting_reg + `UGLS_ATT_STEP; // RQ4 RQ9
                o_saved_setting <= setting_reg + `UGLS_ATT_STEP; // RQ5
                o_save_strobe <= 1'b1;
            end
            if (wr_hit && i_avs_address == `UGLS_REG_CTRL) begin
                enable_reg <= i_avs_writedata[`UGLS_CTRL_ENABLE];
                rf_on_reg <= i_avs_writedata[`UGLS_CTRL_RF_ON];
                if (!i_avs_writedata[`UGLS_CTRL_ENABLE]) begin
                    setting_reg <= setting_reg;
                end else begin
                    setting_reg <= clamp_att(setting_reg, `UGLS_ATT_AUTO_MAX); // RQ13
                end
            end
            if (wr_hit && i_avs_address == `UGLS_REG_MASK) begin
                mask_reg <= i_avs_writedata[`UGLS_EVT_W-1:0];
            end
            if (!enable_reg) begin
                // Manual: open loop, no monitoring, window restarts on re-enable
                drive_reg <= setting_reg; // RQ11 RQ12
                low_reg <= 1'b0;
                high_reg <= 1'b0;
                loop_reg <= 1'b0;
                in_low_prev_reg <= 1'b0;
                in_high_prev_reg <= 1'b0;
                win_ptr_reg <= `UGLS_ZERO8;
                win_count_reg <= `UGLS_ZERO8;
                win_full_reg <= 1'b0;
                old_ok_reg <= 1'b0;
            end else if (i_iter_strobe) begin
                in_low_prev_reg <= in_low;
                in_high_prev_reg <= in_high;
                cur_nz_reg <= nz_now;
                // Oldest slot holds real history only after one full pass
                old_ok_reg <= win_full_reg; // RQ15
                if (low_evt) begin
                    low_reg <= 1'b1; // RQ8
                end else if (!in_low) begin
                    low_reg <= 1'b0;
                end
                if (high_evt) begin
                    high_reg <= 1'b1; // RQ9
                end else if (!in_high) begin
                    high_reg <= 1'b0;
                end
                if (win_ptr_reg == `UGLS_WIN_LEN - `UGLS_ONE8) begin
                    win_ptr_reg <= `UGLS_ZERO8;
                    win_full_reg <= 1'b1;
                end else begin
                    win_ptr_reg <= win_ptr_reg + `UGLS_ONE8;
                end
                if (in_low) begin
                    drive_reg <= `UGLS_ATT_MAN_MAX; // RQ2 RQ8
                    ramp_reg <= `UGLS_ZERO4;
                end else if (drive_reg > setting_reg + i_gain_error_db[5:0]
                             && ramp_reg == `UGLS_RAMP_DIV) begin
                    drive_reg <= drive_reg - `UGLS_ATT_STEP; // RQ3
                    ramp_reg <= `UGLS_ZERO4;
                end else if (drive_reg > setting_reg + i_gain_error_db[5:0]) begin
                    ramp_reg <= ramp_reg + `UGLS_ONE4; // RQ3
                end else begin
                    // Error is applied as trim on top of user setting
                    drive_reg <= clamp_att(setting_reg + i_gain_error_db[5:0],
                        `UGLS_ATT_MAN_MAX); // RQ14
                end
            end else if (iter_d_reg) begin
                win_count_reg <= count_next; // RQ6
                loop_reg <= loop_now; // RQ6 RQ15
            end
            o_atten_drive <= drive_reg;
            o_summary_fault <= enable_reg && (loop_reg || low_reg || high_reg); // RQ6 RQ11
            o_irq <= |(status_next & mask_reg);
        end
    end
endmodule // ugls_top
`default_nettype wire

// *** src/ugls_map.vh ***
// Register map, field layout and constants for the uplink gain loop supervisor
`ifndef UGLS_MAP_VH
`define UGLS_MAP_VH
// Register word addresses
`define UGLS_REG_CTRL     4'h0
`define UGLS_REG_SETTING  4'h1
`define UGLS_REG_STATUS   4'h2
`define UGLS_REG_MASK     4'h3
`define UGLS_REG_FAULTS   4'h4
`define UGLS_REG_ATTEN    4'h5
// Control bits
`define UGLS_CTRL_ENABLE  0
`define UGLS_CTRL_RF_ON   1
`define UGLS_CTRL_START   2
// Fault and status bits
`define UGLS_F_LOOP       0
`define UGLS_F_LOW        1
`define UGLS_F_HIGH       2
`define UGLS_F_SAT        3
`define UGLS_F_SUMMARY    4
`define UGLS_F_DECIMAL    5
`define UGLS_EVT_W        4
`define UGLS_EVT_ZERO     4'h0
// Attenuation limits in dB
`define UGLS_ATT_AUTO_MAX 6'h14
`define UGLS_ATT_MAN_MAX  6'h37
`define UGLS_ATT_ZERO     6'h00
`define UGLS_ATT_STEP     6'h01
// Input power thresholds in dBm, signed
`define UGLS_LOW_DBM      8'hD3
`define UGLS_HIGH_DBM     8'hE7
// Loop fault window
`define UGLS_WIN_LEN      8'hFF
`define UGLS_WIN_LIMIT    8'h05
`define UGLS_ZERO8        8'h00
`define UGLS_ONE8         8'h01
// Ramp of one step each period of iterations
`define UGLS_RAMP_DIV     4'hF
`define UGLS_ZERO4        4'h0
`define UGLS_ONE4         4'h1
`endif

// *** src/ugls_hist_mem.v ***
// Sliding window memory of nonzero-error history bits
`timescale 1ns/100ps
`default_nettype none
module ugls_hist_mem (
    // Clock and reset
    input wire i_sys_clk,
    input wire i_resetn,
    // Write port
    input wire i_wr_en,
    input wire [7:0] i_wr_addr,
    input wire i_wr_data,
    // Read port
    input wire [7:0] i_rd_addr,
    output reg o_rd_data
);
    reg mem_reg [0:254];
    always @(posedge i_sys_clk) begin
        if (i_wr_en) begin
            mem_reg[i_wr_addr] <= i_wr_data;
        end
    end
    // Registered read; content undefined until the window has filled once
    always @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rd_data <= 1'b0;
        end else begin
            o_rd_data <= mem_reg[i_rd_addr];
        end
    end
endmodule // ugls_hist_mem
`default_nettype wire

// *** testbench/ugls_properties.sv ***
// Port checker for the uplink gain loop supervisor
`timescale 1ns/100ps
`default_nettype none
`include "ugls_map.vh"
module ugls_checker (
    // Clock, reset and watched ports
    input wire i_sys_clk,
    input wire i_resetn,
    input wire [3:0] i_avs_address,
    input wire i_avs_read,
    input wire i_avs_write,
    input wire [31:0] i_avs_writedata,
    input wire o_avs_waitrequest,
    input wire i_iter_strobe,
    input wire signed [7:0] i_in_power_dbm,
    input wire i_in_present,
    input wire [5:0] o_atten_drive,
    input wire [5:0] o_saved_setting,
    input wire o_save_strobe,
    input wire o_summary_fault
);
    reg en_q;
    reg norm_q;
    wire low_w = !i_in_present || (i_in_power_dbm <= $signed(`UGLS_LOW_DBM));
    wire high_w = i_in_present && (i_in_power_dbm > $signed(`UGLS_HIGH_DBM));
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);
    // ****************************
    // Mode mirror, registers are not visible here
    // ****************************
    always @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            en_q <= 1'b1;
            norm_q <= 1'b0;
        end else begin
            if (i_avs_write && !o_avs_waitrequest && i_avs_address == `UGLS_REG_CTRL)
                en_q <= i_avs_writedata[`UGLS_CTRL_ENABLE];
            if (i_iter_strobe)
                norm_q <= !low_w && !high_w;
        end
    end
    bus_answer_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
        |=> !o_avs_waitrequest) else $error("request not answered next cycle");
    bus_pulse_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    low_max_a: assert property (en_q && i_iter_strobe && low_w
        |-> ##[1:2] o_atten_drive == `UGLS_ATT_MAN_MAX) else $error("low input not at max");
    low_fault_a: assert property (en_q && i_iter_strobe && norm_q && low_w
        |-> ##[1:2] o_summary_fault) else $error("low input not flagged");
    high_fault_a: assert property (en_q && i_iter_strobe && norm_q && high_w
        |-> ##[1:2] o_summary_fault) else $error("high input not flagged");
    manual_ok_a: assert property ((!en_q)[*3] |-> !o_summary_fault)
        else $error("summary fault in manual mode");
    drive_range_a: assert property (o_atten_drive <= `UGLS_ATT_MAN_MAX)
        else $error("drive above manual maximum");
    auto_limit_a: assert property (en_q && o_save_strobe
        |-> o_saved_setting <= `UGLS_ATT_AUTO_MAX) else $error("auto setting above limit");
endmodule // ugls_checker
bind ugls_top ugls_checker i_chk (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .o_avs_waitrequest(o_avs_waitrequest),
    .i_iter_strobe(i_iter_strobe), .i_in_power_dbm(i_in_power_dbm),
    .i_in_present(i_in_present), .o_atten_drive(o_atten_drive),
    .o_saved_setting(o_saved_setting), .o_save_strobe(o_save_strobe),
    .o_summary_fault(o_summary_fault));
`default_nettype wire

// *** testbench/ugls_partner.sv ***
// Amplifier detector and loop timing model
`timescale 1ns/100ps
`default_nettype none
module ugls_partner #(parameter int ITER_DIV = 4) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    // Attenuator drive and overdrive request
    input wire logic [5:0] i_atten_drive,
    input wire logic i_overdrive,
    // Loop timing and detector
    output logic o_iter_strobe,
    output logic o_pa_saturated
);
    int cnt;
    // Fixed iteration rate keeps loop timing predictable
    always @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt <= 0;
            o_iter_strobe <= 1'b0;
        end else begin
            cnt <= (cnt == ITER_DIV - 1) ? 0 : cnt + 1;
            o_iter_strobe <= (cnt == ITER_DIV - 1);
        end
    end
    // Leaves saturation once drive backs off to 20 dB or the overdrive request drops
    assign o_pa_saturated = i_overdrive && (i_atten_drive < 6'h14);
endmodule // ugls_partner
`default_nettype wire

// *** testbench/test_ugls_top.sv ***
// Bench for the uplink gain loop supervisor
`timescale 1ns/100ps
`default_nettype none
`include "ugls_map.vh"
module test_ugls_top;
    logic i_sys_clk = 1'b0, i_resetn = 1'b0, i_avs_read = 1'b0, i_avs_write = 1'b0;
    logic [3:0] i_avs_address = 4'h0;
    logic [31:0] i_avs_writedata = 32'h0, q;
    logic [5:0] i_saved_setting = 6'h07;
    logic signed [7:0] i_in_power_dbm = 8'hE2, i_gain_error_db = 8'h00;
    logic i_in_present = 1'b1, ovd = 1'b0;
    wire [31:0] o_avs_readdata;
    wire [5:0] o_saved_setting, o_atten_drive;
    wire o_avs_waitrequest, o_save_strobe, o_summary_fault, o_irq, i_iter_strobe, i_pa_saturated;
    int num_errors = 0, compares = 0, cycles = 0, saves = 0;
    always #2 i_sys_clk = ~i_sys_clk;
    ugls_top i_dut (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_avs_address(i_avs_address),
        .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
        .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
        .i_saved_setting(i_saved_setting), .o_saved_setting(o_saved_setting),
        .o_save_strobe(o_save_strobe), .i_iter_strobe(i_iter_strobe),
        .i_in_power_dbm(i_in_power_dbm), .i_in_present(i_in_present),
        .i_gain_error_db(i_gain_error_db), .i_pa_saturated(i_pa_saturated),
        .o_atten_drive(o_atten_drive), .o_summary_fault(o_summary_fault), .o_irq(o_irq));
    ugls_partner i_pa (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
        .i_atten_drive(o_atten_drive), .i_overdrive(ovd),
        .o_iter_strobe(i_iter_strobe), .o_pa_saturated(i_pa_saturated));
    // ****************************
    // Bus tasks, timeout and verdict
    // ****************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        i_avs_write <= w;
        i_avs_read <= !w;
        i_avs_address <= a;
        i_avs_writedata <= d;
        do @(posedge i_sys_clk); while (o_avs_waitrequest !== 1'b0);
        q = o_avs_readdata;
        i_avs_write <= 1'b0;
        i_avs_read <= 1'b0;
        @(posedge i_sys_clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q & m, e);
    endtask
    task automatic it(input int n);
        repeat (n * 4) @(posedge i_sys_clk);
    endtask
    task close_out;
        $display("compares=%0d num_errors=%0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Ceiling well above the roughly 8000 cycles the tests take
    always @(posedge i_sys_clk) begin
        cycles <= cycles + 1;
        if (o_save_strobe === 1'b1)
            saves <= saves + 1;
        if (cycles == 20000) begin
            num_errors++;
            close_out;
        end
    end
    initial begin
        repeat (10) @(posedge i_sys_clk);
        i_resetn <= 1'b1;
        repeat (2) @(posedge i_sys_clk);
        rd(`UGLS_REG_CTRL, 32'h3, 32'h3);
        rd(`UGLS_REG_SETTING, 32'h3F, 32'h07);
        rd(4'hF, 32'hFFFFFFFF, 32'h0);
        wr(`UGLS_REG_SETTING, 32'h30);
        rd(`UGLS_REG_SETTING, 32'h3F, `UGLS_ATT_AUTO_MAX);
        rd(`UGLS_REG_FAULTS, 32'h20, 32'h20);
        wr(`UGLS_REG_CTRL, 32'h2);
        wr(`UGLS_REG_SETTING, 32'h3F);
        rd(`UGLS_REG_SETTING, 32'h3F, `UGLS_ATT_MAN_MAX);
        rd(`UGLS_REG_FAULTS, 32'h3F, 32'h0);
        chk(o_atten_drive, `UGLS_ATT_MAN_MAX);
        wr(`UGLS_REG_SETTING, 32'h5);
        wr(`UGLS_REG_CTRL, 32'h3);
        it(20);
        chk(o_atten_drive, 32'h5);
        $display("setting and mode test done");
        i_in_power_dbm <= 8'hD0;
        it(3);
        chk(o_atten_drive, `UGLS_ATT_MAN_MAX);
        chk(o_summary_fault, 32'h1);
        rd(`UGLS_REG_SETTING, 32'h3F, 32'h5);
        rd(`UGLS_REG_FAULTS, 32'h2, 32'h2);
        wr(`UGLS_REG_MASK, 32'h2);
        it(1);
        chk(o_irq, 32'h1);
        wr(`UGLS_REG_STATUS, 32'hF);
        chk(o_irq, 32'h0);
        i_in_present <= 1'b0;
        i_in_power_dbm <= 8'hE2;
        it(2);
        chk(o_atten_drive, `UGLS_ATT_MAN_MAX);
        i_in_present <= 1'b1;
        it(2);
        chk(o_atten_drive > 6'h05, 32'h1);
        it(832);
        chk(o_atten_drive, 32'h5);
        $display("low input test done");
        i_in_power_dbm <= 8'hE8;
        it(2);
        rd(`UGLS_REG_FAULTS, 32'h14, 32'h14);
        i_in_power_dbm <= 8'hE2;
        i_gain_error_db <= 8'h02;
        it(4);
        rd(`UGLS_REG_FAULTS, 32'h1, 32'h0);
        it(4);
        rd(`UGLS_REG_FAULTS, 32'h1, 32'h1);
        i_gain_error_db <= 8'h00;
        it(260);
        rd(`UGLS_REG_FAULTS, 32'h1, 32'h0);
        wr(`UGLS_REG_CTRL, 32'h1);
        it(8);
        rd(`UGLS_REG_FAULTS, 32'h1, 32'h1);
        wr(`UGLS_REG_CTRL, 32'h3);
        it(260);
        $display("fault test done");
        ovd <= 1'b1;
        it(500);
        rd(`UGLS_REG_SETTING, 32'h3F, `UGLS_ATT_AUTO_MAX);
        chk(saves > 0, 32'h1);
        chk(o_saved_setting, `UGLS_ATT_AUTO_MAX);
        ovd <= 1'b0;
        i_in_power_dbm <= 8'hD8;
        it(20);
        rd(`UGLS_REG_SETTING, 32'h3F, `UGLS_ATT_AUTO_MAX);
        wr(`UGLS_REG_CTRL, 32'h2);
        i_in_power_dbm <= 8'hD0;
        it(4);
        chk(o_summary_fault, 32'h0);
        $display("saturation and manual test done");
        i_saved_setting <= `UGLS_ATT_AUTO_MAX;
        i_resetn <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
        i_resetn <= 1'b1;
        repeat (2) @(posedge i_sys_clk);
        rd(`UGLS_REG_SETTING, 32'h3F, `UGLS_ATT_AUTO_MAX);
        rd(`UGLS_REG_CTRL, 32'h3, 32'h3);
        $display("restore test done");
        close_out;
    end
endmodule // test_ugls_top
`default_nettype wire
